//--- tb_top.sv
// Self-checking testbench for the watchdog reset timer
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   import wdt_pkg::*;

   // ==========================================================
   // Stimulus and observation signals
   // ==========================================================
   typedef struct {
      logic w;                                       // Write when one, read otherwise
      logic [17:0] a;                                // Byte address
      logic [7:0] d;                                 // Write data
      logic [7:0] e;                                 // Expected read data
   } wdt_row_s;

   localparam logic [17:0] A_CTL = {CTL_IDX, 2'b00}; // Control register byte address
   localparam logic [17:0] A_CNT = {CNT_IDX, 2'b00}; // Counter byte address
   localparam logic [17:0] A_UNM = 18'h00010;        // Nothing mapped here

   logic clk_i = 1'b0;                               // System clock
   logic rst_i = 1'b1;                               // Pin reset
   logic ce_i = 1'b1;                                // Clock enable
   logic halt_i = 1'b0;                              // Low-power mode
   logic osc_clk_i = 1'b0;                           // Free-running oscillator
   logic cyc_i = 1'b0;                               // Bus cycle
   logic stb_i = 1'b0;                               // Bus strobe
   logic we_i = 1'b0;                                // Bus write
   logic [17:0] adr_i = 18'h00000;                   // Bus address
   logic [31:0] dat_i = 32'h0000_0000;               // Bus write data
   logic [31:0] dat_o;                               // Bus read data
   logic ack_o;                                      // Bus acknowledge
   logic chip_reset_o;                               // Chip reset out
   int err_total = 0;                                // Mismatches
   int tests_run = 0;                                // Comparisons
   logic [31:0] rd;                                  // Last read data
   logic [31:0] rd2;                                 // Second read data
   int n;                                            // Cycle counter

   // Ordinary cases: inputs beside expected read data
   wdt_row_s rows [0:15] = '{
      '{1'b0, A_CTL, 8'h00, 8'haa},                  // Reset value, guards read one
      '{1'b0, A_CNT, 8'h00, 8'h00},                  // Counter zero after reset
      '{1'b1, A_CNT, 8'h55, 8'h00},                  // Counter write blocked
      '{1'b0, A_CNT, 8'h00, 8'h00},
      '{1'b1, A_CTL, 8'h10, 8'h00},                  // Open register permit only
      '{1'b0, A_CTL, 8'h00, 8'hba},
      '{1'b1, A_CTL, 8'hff, 8'h00},                  // All guards set, nothing moves
      '{1'b0, A_CTL, 8'h00, 8'hba},
      '{1'b1, A_CTL, 8'h11, 8'h00},                  // Flag write of one ignored
      '{1'b0, A_CTL, 8'h00, 8'hba},
      '{1'b1, A_CTL, 8'h70, 8'h00},                  // Open counter permit
      '{1'b0, A_CTL, 8'h00, 8'hfa},
      '{1'b1, A_CNT, 8'h55, 8'h00},                  // Counter write accepted
      '{1'b0, A_CNT, 8'h00, 8'h55},
      '{1'b1, A_UNM, 8'hff, 8'h00},                  // Unmapped write
      '{1'b0, A_UNM, 8'h00, 8'h00}                   // Unmapped read is zero
   };

   // ==========================================================
   // Design under test, short counts
   // ==========================================================
   wdt_top #(.PRESCALE_DIV(4), .RESET_OSC_CYCLES(4)) wdt_top_i (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .halt_i(halt_i), .osc_clk_i(osc_clk_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .chip_reset_o(chip_reset_o)
   );

   // Clocks: 25 ns system, 100 ns oscillator
   always #12.5 clk_i = ~clk_i;
   always #50 osc_clk_i = ~osc_clk_i;

   // ==========================================================
   // Shared tasks
   // ==========================================================
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One classic bus cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d, output logic [31:0] r);
      int k;
      k = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h000000, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1 && k < 40) begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 40) begin
         chk(32'h0, 32'h1);
      end
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // Verdict and end of run
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      #(25 * 20000);
      err_total++;
      report_and_stop();
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      // Table of ordinary register cases
      for (int i = 0; i < 16; i++) begin
         bus(rows[i].w, rows[i].a, rows[i].d, rd);
         if (!rows[i].w) chk(rd, {24'h000000, rows[i].e});
      end
      // Overflow: load fc, start, four ticks to rollover
      bus(1'b1, A_CNT, 8'hfc, rd);
      bus(1'b1, A_CTL, 8'ha6, rd);
      n = 0;
      while (chip_reset_o !== 1'b1 && n < 60) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(n >= 14 && n <= 20), 32'h1);
      n = 0;
      while (chip_reset_o === 1'b1 && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(n >= 12 && n <= 26), 32'h1);
      bus(1'b0, A_CTL, 8'h00, rd);
      chk(rd, 32'h0000_00ab);
      bus(1'b0, A_CNT, 8'h00, rd);
      chk(rd, 32'h0000_0000);
      // Flag clear needs the permit from before the write
      bus(1'b1, A_CTL, 8'h10, rd);
      bus(1'b0, A_CTL, 8'h00, rd);
      chk(rd, 32'h0000_00bb);
      bus(1'b1, A_CTL, 8'h10, rd);
      bus(1'b0, A_CTL, 8'h00, rd);
      chk(rd, 32'h0000_00ba);
      // Counting while on, frozen in halt, stopped when off
      bus(1'b1, A_CTL, 8'h5a, rd);
      bus(1'b1, A_CNT, 8'h10, rd);
      bus(1'b1, A_CTL, 8'ha6, rd);
      bus(1'b0, A_CTL, 8'h00, rd);
      chk(rd, 32'h0000_00fe);
      repeat (20) @(posedge clk_i);
      bus(1'b0, A_CNT, 8'h00, rd);
      chk(32'(rd[7:0] > 8'h10 && rd[7:0] < 8'h20), 32'h1);
      halt_i <= 1'b1;
      bus(1'b0, A_CNT, 8'h00, rd);
      repeat (20) @(posedge clk_i);
      bus(1'b0, A_CNT, 8'h00, rd2);
      chk(rd2, rd);
      bus(1'b0, A_CTL, 8'h00, rd);
      chk(rd, 32'h0000_00fe);
      halt_i <= 1'b0;
      bus(1'b1, A_CTL, 8'ha2, rd);
      bus(1'b0, A_CNT, 8'h00, rd);
      repeat (20) @(posedge clk_i);
      bus(1'b0, A_CNT, 8'h00, rd2);
      chk(rd2, rd);
      bus(1'b0, A_CTL, 8'h00, rd);
      chk(rd, 32'h0000_00fa);
      // Clock enable low freezes a running counter
      bus(1'b1, A_CTL, 8'ha6, rd);
      bus(1'b0, A_CNT, 8'h00, rd);
      ce_i <= 1'b0;
      repeat (40) @(posedge clk_i);
      ce_i <= 1'b1;
      bus(1'b0, A_CNT, 8'h00, rd2);
      chk(32'((rd2[7:0] - rd[7:0]) <= 8'h02), 32'h1);
      // Pin reset in mid-run returns every register to its reset value
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({dat_o[7:0], ack_o, chip_reset_o}, 32'h0);
      bus(1'b0, A_CTL, 8'h00, rd);
      chk(rd, 32'h0000_00aa);
      bus(1'b0, A_CNT, 8'h00, rd);
      chk(rd, 32'h0000_0000);
      report_and_stop();
   end
endmodule // tb_top

`default_nettype wire

//--- wdt_pkg.sv
// Package of constants shared by the watchdog reset timer files
package wdt_pkg;

   // ==========================================================
   // Register map (word indexes; byte address is index times 4)
   // ==========================================================
   localparam int unsigned ADR_W = 18;               // Byte address width on the bus
   localparam int unsigned IDX_W = 16;               // Word index width
   localparam logic [15:0] CTL_IDX = 16'hffbe;       // watchdog_control_status
   localparam logic [15:0] CNT_IDX = 16'hffbf;       // watchdog_counter

   // ==========================================================
   // Field positions of watchdog_control_status
   // ==========================================================
   localparam int unsigned B_CW_GUARD = 7;           // counter_enable_guard
   localparam int unsigned B_CW = 6;                 // counter_write_permit
   localparam int unsigned B_RW_GUARD = 5;           // register_permit_guard
   localparam int unsigned B_RW = 4;                 // register_write_permit
   localparam int unsigned B_RUN_GUARD = 3;          // run_guard
   localparam int unsigned B_RUN = 2;                // watchdog_run
   localparam int unsigned B_FLAG_GUARD = 1;         // flag_guard
   localparam int unsigned B_FLAG = 0;               // overflow_reset_flag

   // ==========================================================
   // Reset values and masks
   // ==========================================================
   localparam logic [7:0] CTL_RESET = 8'haa;         // Control register after reset
   localparam logic [7:0] GUARD_MASK = 8'haa;        // Guard bits always read as one
   localparam logic [7:0] CNT_RESET = 8'h00;         // Counter after reset
   localparam logic [7:0] CNT_MAX = 8'hff;           // Last count before rollover
   localparam logic [31:0] RD_NONE = 32'h0000_0000;  // Answer to an unmapped read

   // ==========================================================
   // Timing counts
   // ==========================================================
   localparam int unsigned PRESCALE_DIV_DEF = 8192;  // System clocks per counter tick
   localparam int unsigned RESET_OSC_DEF = 512;      // Oscillator cycles of chip reset

   // ==========================================================
   // Internal reset sequencer states
   // ==========================================================
   typedef enum logic [0:0] {
      WDT_NORMAL = 1'b0,                             // Chip running
      WDT_HOLD = 1'b1                                // Chip held in reset
   } wdt_state_e;

endpackage : wdt_pkg

//--- wdt_prescale.sv
// Prescaler that divides the system clock into watchdog counter ticks
`timescale 1ns/10ps
`default_nettype none

module wdt_prescale #(
   parameter int unsigned DIV = 8192                 // System clocks per tick
) (
   input wire logic clk_i,                           // System clock
   input wire logic rst_i,                           // Synchronous reset, high
   input wire logic ce_i,                            // Clock enable, freezes all
   input wire logic run_i,                           // Count while high, clear when low
   output logic tick_o                               // One-cycle tick pulse
);
   import wdt_pkg::*;

   localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);    // Final phase before a tick

   logic [CW-1:0] phase;                             // Divider phase
   wire at_last = (phase == LAST);                   // Divider wraps this cycle

   // ==========================================================
   // Divider: restarts whenever counting is off so every period
   // is a whole number of ticks from the enabling write
   // ==========================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase <= '0;
         tick_o <= 1'b0;
      end else if (ce_i) begin
         if (!run_i) begin
            phase <= '0;
            tick_o <= 1'b0;
         end else begin
            phase <= at_last ? '0 : CW'(phase + 1'b1);
            tick_o <= at_last;
         end
      end
   end

endmodule // wdt_prescale
`default_nettype wire

//--- wdt_top.sv
// Watchdog reset timer with a classic Wishbone register slave
//
// Chosen here: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - 8-bit counter ticks at system clock over 8192
// - Rollover from ff requests reset, sets flag
// - Internal reset lasts 512 oscillator cycles
// - Internal reset drives the whole chip
// - Counter write reloads; counting continues from it
// - Counter is zero after reset
// - Bit 6 permits counter writes, resets to 0
// - Bit 6 changes only when bit 7 written 0
// - Bit 4 changes only when bit 5 written 0
// - Bits 2 and 0 writable only while bit 4
// - Guard bits read one and store nothing
// - Bit 2 changes only when bit 3 written 0
// - Run set by permitted write of 0,1
// - Run cleared by reset or permitted 0,0
// - Counter advances only while run is one
// - Flag cleared by pin reset or permitted 0,0
// - Low-power modes halt counter, keep control
module wdt_top #(
   parameter int unsigned PRESCALE_DIV = wdt_pkg::PRESCALE_DIV_DEF,  // Clocks per tick
   parameter int unsigned RESET_OSC_CYCLES = wdt_pkg::RESET_OSC_DEF  // Reset length
) (
   input wire logic clk_i,                           // System clock, 40 MHz
   input wire logic rst_i,                           // Pin reset, synchronous, high
   input wire logic ce_i,                            // Clock enable
   input wire logic halt_i,                          // Watch, subactive, subsleep or standby
   input wire logic osc_clk_i,                       // Oscillator clock pin
   input wire logic cyc_i,                           // Wishbone cycle
   input wire logic stb_i,                           // Wishbone strobe
   input wire logic we_i,                            // Wishbone write
   input wire logic [wdt_pkg::ADR_W-1:0] adr_i,      // Wishbone byte address
   input wire logic [3:0] sel_i,                     // Wishbone byte selects
   input wire logic [31:0] dat_i,                    // Wishbone write data
   output logic [31:0] dat_o,                        // Wishbone read data
   output logic ack_o,                               // Wishbone acknowledge
   output logic chip_reset_o                         // Chip-wide internal reset
);
   import wdt_pkg::*;

   localparam int unsigned OW = $clog2(RESET_OSC_CYCLES + 1);
   localparam logic [OW-1:0] OSC_LAST = OW'(RESET_OSC_CYCLES - 1);

   // Open test on a guard bit within the write data
   function automatic logic guard_open(input logic [7:0] d, input int unsigned g);
      return ~d[g];
   endfunction

   // ==========================================================
   // State
   // ==========================================================
   wdt_state_e state;                                // Internal reset sequencer
   wdt_state_e next_state;                           // Its next value
   logic [7:0] cnt;                                  // watchdog_counter
   logic cw;                                         // counter_write_permit
   logic rw;                                         // register_write_permit
   logic run;                                        // watchdog_run
   logic flag;                                       // overflow_reset_flag
   logic [OW-1:0] osc_cnt;                           // Oscillator edges while held
   logic osc_s1;                                     // Oscillator sync stage 1
   logic osc_s2;                                     // Oscillator sync stage 2
   logic osc_s3;                                     // Oscillator sync stage 3
   logic osc_lvl;                                    // Accepted oscillator level
   logic tick;                                       // Prescaled tick

   // ==========================================================
   // Bus decode
   // ==========================================================
   wire [IDX_W-1:0] idx = adr_i[ADR_W-1:2];          // Word index
   wire is_ctl = (idx == CTL_IDX);                   // Control register hit
   wire is_cnt = (idx == CNT_IDX);                   // Counter register hit
   wire bus_req = cyc_i & stb_i & ~ack_o;            // New request waiting
   wire bus_end = cyc_i & stb_i & ack_o & ce_i;      // Edge where master takes ack
   wire wr_lane = we_i & sel_i[0];                   // Low byte written
   wire hold = (state == WDT_HOLD);                  // Chip held in reset
   wire [7:0] wd = dat_i[7:0];                       // Written byte

   // Writes land on the edge at which the master samples ack
   wire wr_ctl = bus_end & wr_lane & is_ctl & ~hold;
   wire wr_cnt_ok = bus_end & wr_lane & is_cnt & cw & ~hold;

   // ==========================================================
   // Field updates, each gated by its own guard bit
   // ==========================================================
   wire cw_wr = wr_ctl & guard_open(wd, B_CW_GUARD);
   wire rw_wr = wr_ctl & guard_open(wd, B_RW_GUARD);
   wire run_wr = wr_ctl & rw & guard_open(wd, B_RUN_GUARD);
   wire flag_clr = wr_ctl & rw & guard_open(wd, B_FLAG_GUARD)
      & ~wd[B_FLAG];
   wire next_cw = cw_wr ? wd[B_CW] : cw;             // Counter permit
   wire next_rw = rw_wr ? wd[B_RW] : rw;             // Register permit
   wire next_run = run_wr ? wd[B_RUN] : run;

   // ==========================================================
   // Counter datapath
   // ==========================================================
   // Counting stops in low-power modes and while run is clear
   wire cnt_go = tick & run & ~halt_i & ~hold;
   // A software reload beats a tick that lands in the same cycle
   wire ovf = cnt_go & ~wr_cnt_ok & (cnt == CNT_MAX);
   wire [7:0] cnt_inc = 8'(cnt + 8'h01);
   wire [7:0] next_cnt = wr_cnt_ok ? wd :
      cnt_go ? cnt_inc : cnt;
   // Overflow sets the flag and wins over a clearing write
   wire next_flag = ovf | (flag & ~flag_clr);

   // ==========================================================
   // Read view
   // ==========================================================
   wire [7:0] ctl_view = GUARD_MASK
      | (8'(cw) << B_CW) | (8'(rw) << B_RW)
      | (8'(run) << B_RUN) | (8'(flag) << B_FLAG);
   wire [31:0] rd_mux = is_ctl ? {24'h000000, ctl_view} :
      is_cnt ? {24'h000000, cnt} : RD_NONE;

   // ==========================================================
   // Oscillator edge detection
   // ==========================================================
   wire osc_agree = (osc_s2 == osc_s3);              // Stages 2 and 3 agree
   wire osc_edge = osc_agree & osc_s3 & ~osc_lvl;    // Accepted rising edge
   wire osc_done = osc_edge & (osc_cnt == OSC_LAST);

   // Sequencer next state
   always_comb begin
      next_state = state;
      unique case (state)
         WDT_NORMAL: begin
            if (ovf) begin
               next_state = WDT_HOLD;
            end
         end
         WDT_HOLD: begin
            if (osc_done) begin
               next_state = WDT_NORMAL;
            end
         end
      endcase
   end

   // ==========================================================
   // Prescaler
   // ==========================================================
   wdt_prescale #(
      .DIV(PRESCALE_DIV)
   ) u_prescale (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .run_i(run & ~halt_i & ~hold),
      .tick_o(tick)
   );

   // Oscillator synchroniser, three stages
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
         osc_s3 <= 1'b0;
         osc_lvl <= 1'b0;
      end else if (ce_i) begin
         osc_s1 <= osc_clk_i;
         osc_s2 <= osc_s1;
         osc_s3 <= osc_s2;
         if (osc_agree) begin
            osc_lvl <= osc_s3;
         end
      end
   end

   // Internal reset sequencer and its length count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= WDT_NORMAL;
         chip_reset_o <= 1'b0;
         osc_cnt <= '0;
      end else if (ce_i) begin
         state <= next_state;
         chip_reset_o <= (next_state == WDT_HOLD);
         if (!hold || osc_done) begin
            osc_cnt <= '0;
         end else if (osc_edge) begin
            osc_cnt <= OW'(osc_cnt + 1'b1);
         end
      end
   end

   // Control fields and counter; internal reset spares the flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= CNT_RESET;
         {cw, rw, run} <= 3'b000;
         flag <= 1'b0;
      end else if (ce_i) begin
         if (ovf || hold) begin
            cnt <= CNT_RESET;
            {cw, rw, run} <= 3'b000;
         end else begin
            cnt <= next_cnt;
            {cw, rw, run} <= {next_cw, next_rw, next_run};
         end
         flag <= next_flag;
      end
   end

   // Wishbone slave: ack one cycle after the request, dropped next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= RD_NONE;
      end else if (ce_i) begin
         ack_o <= bus_req;
         if (bus_req && !we_i) begin
            dat_o <= rd_mux;
         end
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   cnt_reset_val_a: assert property ($fell(rst_i) |-> cnt == CNT_RESET)
      else $error("counter not zero after reset");

   guard_read_one_a: assert property (
      (bus_req && ce_i && !we_i && is_ctl) |=> ((dat_o[7:0] & GUARD_MASK) == GUARD_MASK))
      else $error("guard bits did not read as one");

   cnt_write_block_a: assert property (
      (bus_end && wr_lane && is_cnt && !cw && !cnt_go && !hold)
      |=> cnt == $past(cnt))
      else $error("blocked counter write changed count");

   cnt_write_take_a: assert property (
      (wr_cnt_ok && !ovf) |=> cnt == $past(wd))
      else $error("counter write not taken");

   permit_guard_hold_a: assert property (
      (wr_ctl && !ovf && wd[B_CW_GUARD]) |=> cw == $past(cw))
      else $error("guarded counter permit changed");

   reg_guard_hold_a: assert property (
      (wr_ctl && !ovf && wd[B_RW_GUARD]) |=> rw == $past(rw))
      else $error("guarded register permit changed");

   run_set_write_a: assert property (
      (wr_ctl && !ovf && rw && !wd[B_RUN_GUARD] && wd[B_RUN]) |=> run ##1 (run || !ce_i || wr_ctl || hold))
      else $error("run not set by permitted write");

   run_clear_write_a: assert property (
      (wr_ctl && rw && !wd[B_RUN_GUARD] && !wd[B_RUN]) |=> !run)
      else $error("run not cleared by permitted write");

   run_locked_a: assert property (
      (wr_ctl && !rw && !ovf) |=> run == $past(run))
      else $error("run changed without register permit");

   flag_clear_write_a: assert property (
      (flag_clr && !ovf && ce_i) |=> !flag)
      else $error("flag not cleared by permitted write");

   ovf_sets_flag_a: assert property (ovf |=> flag && chip_reset_o [*2])
      else $error("overflow did not set flag and reset");

   stop_holds_cnt_a: assert property (
      (ce_i && (!run || halt_i) && !wr_cnt_ok && !hold) |=> cnt == $past(cnt))
      else $error("counter moved while stopped");

   reset_length_a: assert property (
      $fell(chip_reset_o) |-> $past(osc_cnt) == OSC_LAST)
      else $error("internal reset length wrong");

   ovf_cov_c: cover property (ovf);
   run_set_cov_c: cover property (run_wr && wd[B_RUN]);
   reload_cov_c: cover property (wr_cnt_ok);
   reset_end_cov_c: cover property ($fell(chip_reset_o));

endmodule // wdt_top
`default_nettype wire
